// >>> rtl/dmr_pkg.sv
// package for the doubleword multiply, rotate and move datapath
package dmr_pkg;
  localparam int unsigned DATA_W     = 64;
  localparam int unsigned PROD_W     = 128;
  localparam int unsigned SHAMT_W    = 5;
  localparam int unsigned ROT_W      = 6;
  localparam int unsigned REG_IDX_W  = 5;
  localparam int unsigned SEL_W      = 3;
  localparam int unsigned IMPL_W     = 16;
  localparam int unsigned MUL_LAT    = 4;   // cycles from accept to result write
  localparam int unsigned MUL_CNT_W  = 3;
  localparam logic [DATA_W-1:0] RESULT_RST = 64'h0;
  localparam logic [0:0] ROT32_PREFIX = 1'h1;

  // operation codes presented by the pipeline
  typedef enum logic [3:0] {
    DMR_OP_NONE,
    DMR_OP_SIGNED_MUL,
    DMR_OP_UNSIGNED_MUL,
    DMR_OP_ROT_FIXED,
    DMR_OP_ROT_PLUS32,
    DMR_OP_ROT_VAR,
    DMR_OP_SWAP_BYTES,
    DMR_OP_MOVE_SYS,
    DMR_OP_MOVE_FLOAT,
    DMR_OP_MOVE_FROM_CP2,
    DMR_OP_MOVE_TO_CP2,
    DMR_OP_READ_BOTTOM,
    DMR_OP_READ_UPPER
  } dmr_op_e;

  // exception codes returned with each answer
  typedef enum logic [1:0] {
    DMR_EXC_NONE,
    DMR_EXC_RESERVED,
    DMR_EXC_UNUSABLE
  } dmr_exc_e;
endpackage

// >>> rtl/dmr_cop_if.sv
// interface between the datapath and the coprocessor side
`timescale 1ns/1ns
interface dmr_cop_if;
  import dmr_pkg::*;
  logic                  sys_wr_valid;   // system coprocessor write strobe
  logic [REG_IDX_W-1:0]  sys_wr_index;   // destination index
  logic [SEL_W-1:0]      sys_wr_sel;     // subindex
  logic [DATA_W-1:0]     sys_wr_data;    // doubleword
  logic                  flt_wr_valid;   // float register write strobe
  logic [REG_IDX_W-1:0]  flt_wr_index;   // float target index
  logic [DATA_W-1:0]     flt_wr_data;    // uninterpreted doubleword
  logic                  cp2_wr_valid;   // coprocessor 2 write strobe
  logic                  cp2_rd_req;     // coprocessor 2 read request
  logic [IMPL_W-1:0]     cp2_impl;       // coprocessor-specific field
  logic [DATA_W-1:0]     cp2_wr_data;    // doubleword to coprocessor 2
  logic                  cp2_rd_valid;   // read answer strobe
  logic [DATA_W-1:0]     cp2_rd_data;    // doubleword from coprocessor 2
  logic [2:0]            cop_usable;     // enables for units 0, 1, 2

  modport core (
    output sys_wr_valid, sys_wr_index, sys_wr_sel, sys_wr_data,
    output flt_wr_valid, flt_wr_index, flt_wr_data,
    output cp2_wr_valid, cp2_rd_req, cp2_impl, cp2_wr_data,
    input  cp2_rd_valid, cp2_rd_data, cop_usable
  );
  modport cop (
    input  sys_wr_valid, sys_wr_index, sys_wr_sel, sys_wr_data,
    input  flt_wr_valid, flt_wr_index, flt_wr_data,
    input  cp2_wr_valid, cp2_rd_req, cp2_impl, cp2_wr_data,
    output cp2_rd_valid, cp2_rd_data, cop_usable
  );
endinterface

// >>> rtl/dmr_core.sv
// datapath end: multiply, rotate, byte swap and coprocessor moves
// Summary of operation
// (RULE_01) signed multiply forms full 128-bit product
// (RULE_02) product low half bottom, high half upper
// (RULE_03) unsigned multiply zero-extends both operands
// (RULE_04) multiplies never raise any exception
// (RULE_05) result register reads stall until written
// (RULE_06) fixed rotate right by 0 to 31
// (RULE_07) plus-32 rotate prefixes one to amount
// (RULE_08) variable rotate uses low six bits
// (RULE_09) swap bytes inside every halfword
// (RULE_10) release one raises reserved instruction
// (RULE_11) system move copies all 64 bits
// (RULE_12) unused subindex must be encoded zero; dest_sel is passed on unchecked
// (RULE_13) no doubleword moves to absent registers; every dest_index is moved, none is refused
// (RULE_14) float move stores uninterpreted doubleword
// (RULE_15) coprocessor two read loads target register
// (RULE_16) coprocessor two write delivers register value
// (RULE_17) only coprocessor two decodes its field
// (RULE_18) no moves to absent coprocessor two registers; the low four field bits pick one of 16, none is refused
// (RULE_19) disabled coprocessor gives unusable, no writes
`timescale 1ns/1ns
module dmr_core
  import dmr_pkg::*;
(
  input  wire logic                  ref_clk,       // core clock
  input  wire logic                  rst_n,         // async reset, active low
  input  wire logic                  release_one,   // high on first release cores
  input  wire logic                  op_valid,      // instruction offered
  input  wire dmr_op_e               op_code,       // operation
  input  wire logic [DATA_W-1:0]     src_a,         // value of source_a_index
  input  wire logic [DATA_W-1:0]     src_b,         // value of source_b_index
  input  wire logic [SHAMT_W-1:0]    shift_amount_field, // fixed rotate amount
  input  wire logic [REG_IDX_W-1:0]  dest_index,    // coprocessor register index
  input  wire logic [SEL_W-1:0]      dest_sel,      // subindex
  input  wire logic [IMPL_W-1:0]     impl_field,    // coprocessor 2 field
  output logic                       op_ready,      // instruction taken
  output logic                       res_valid,     // result pulse
  output logic [DATA_W-1:0]          res_data,      // general register result
  output dmr_exc_e                   res_exc,       // exception code
  output logic                       mul_busy,      // multiply in flight
  dmr_cop_if.core                    cop            // coprocessor side
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [DATA_W-1:0] rot_right(input logic [DATA_W-1:0] v,
                                                  input logic [ROT_W-1:0] s);
    rot_right = (v >> s) | (v << (7'(DATA_W) - {1'b0, s}));
  endfunction

  function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W / 16; i++) begin
      r[i*16 +: 8]     = v[i*16 + 8 +: 8];
      r[i*16 + 8 +: 8] = v[i*16 +: 8];
    end
    swap_bytes = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // multiply unit state
  logic [MUL_CNT_W-1:0] mul_cnt;
  logic [PROD_W-1:0]    mul_prod;
  logic [DATA_W-1:0]    bottom_result_reg;
  logic [DATA_W-1:0]    upper_result_reg;
  logic                 cp2_wait;
  logic [PROD_W-1:0]    next_prod;
  logic                 is_mul;
  logic                 is_read;
  logic                 is_cop;
  logic                 cop_ok;
  logic                 take;

  assign is_mul  = (op_code == DMR_OP_SIGNED_MUL) || (op_code == DMR_OP_UNSIGNED_MUL);
  assign is_read = (op_code == DMR_OP_READ_BOTTOM) || (op_code == DMR_OP_READ_UPPER);
  assign is_cop  = (op_code == DMR_OP_MOVE_SYS) || (op_code == DMR_OP_MOVE_FLOAT) ||
                   (op_code == DMR_OP_MOVE_FROM_CP2) || (op_code == DMR_OP_MOVE_TO_CP2);

  // usability check of the targeted coprocessor
  always_comb begin
    unique case (op_code)
      DMR_OP_MOVE_SYS:   cop_ok = cop.cop_usable[0];
      DMR_OP_MOVE_FLOAT: cop_ok = cop.cop_usable[1];
      DMR_OP_MOVE_FROM_CP2,
      DMR_OP_MOVE_TO_CP2: cop_ok = cop.cop_usable[2];
      default:           cop_ok = 1'b1;
    endcase
  end

  // stall result reads and new multiplies while one runs; stall during cp2 read
  assign op_ready = !cp2_wait && !((is_read || is_mul) && mul_busy); // RULE_05
  assign take     = op_valid && op_ready;

  // product formation: signed or zero-extended operands
  always_comb begin
    // sign bits copied by hand so the product is formed at full width on every tool
    if (op_code == DMR_OP_SIGNED_MUL) begin
      next_prod = {{DATA_W{src_a[DATA_W-1]}}, src_a} * {{DATA_W{src_b[DATA_W-1]}}, src_b}; // RULE_01
    end else begin
      next_prod = {{DATA_W{1'b0}}, src_a} * {{DATA_W{1'b0}}, src_b}; // RULE_03
    end
  end

  // multiply runs in the background so later work can issue meanwhile
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mul_cnt  <= '0;
      mul_prod <= '0;
    end else if (take && is_mul) begin
      mul_cnt  <= MUL_CNT_W'(MUL_LAT);
      mul_prod <= next_prod;
    end else if (mul_cnt != '0) begin
      mul_cnt <= mul_cnt - 1'b1;
    end
  end
  assign mul_busy = (mul_cnt != '0);

  // result registers written as the count ends; no overflow check exists
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bottom_result_reg <= RESULT_RST;
      upper_result_reg  <= RESULT_RST;
    end else if (mul_cnt == MUL_CNT_W'(1)) begin
      bottom_result_reg <= mul_prod[DATA_W-1:0];      // RULE_02 RULE_04
      upper_result_reg  <= mul_prod[PROD_W-1:DATA_W]; // RULE_02
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // coprocessor 2 read wait: field is passed through, answer awaited
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp2_wait <= 1'b0;
    end else if (take && op_code == DMR_OP_MOVE_FROM_CP2 && cop_ok) begin
      cp2_wait <= 1'b1;
    end else if (cop.cp2_rd_valid) begin
      cp2_wait <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // coprocessor write strobes, one cycle after the instruction is taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cop.sys_wr_valid <= 1'b0;
      cop.sys_wr_index <= '0;
      cop.sys_wr_sel   <= '0;
      cop.sys_wr_data  <= '0;
      cop.flt_wr_valid <= 1'b0;
      cop.flt_wr_index <= '0;
      cop.flt_wr_data  <= '0;
      cop.cp2_wr_valid <= 1'b0;
      cop.cp2_rd_req   <= 1'b0;
      cop.cp2_impl     <= '0;
      cop.cp2_wr_data  <= '0;
    end else begin
      // disabled unit blocks every write
      cop.sys_wr_valid <= take && cop_ok && op_code == DMR_OP_MOVE_SYS;      // RULE_11 RULE_19
      cop.flt_wr_valid <= take && cop_ok && op_code == DMR_OP_MOVE_FLOAT;    // RULE_14 RULE_19
      cop.cp2_wr_valid <= take && cop_ok && op_code == DMR_OP_MOVE_TO_CP2;   // RULE_16 RULE_19
      cop.cp2_rd_req   <= take && cop_ok && op_code == DMR_OP_MOVE_FROM_CP2; // RULE_15 RULE_19
      // fields load only with their own strobe, so refused or other moves leave them alone
      if (take && cop_ok && op_code == DMR_OP_MOVE_SYS) begin
        cop.sys_wr_index <= dest_index;
        cop.sys_wr_sel   <= dest_sel;
        cop.sys_wr_data  <= src_b;      // RULE_11
      end
      if (take && cop_ok && op_code == DMR_OP_MOVE_FLOAT) begin
        cop.flt_wr_index <= dest_index;
        cop.flt_wr_data  <= src_b;      // RULE_14
      end
      if (take && cop_ok && (op_code == DMR_OP_MOVE_TO_CP2 || op_code == DMR_OP_MOVE_FROM_CP2)) begin
        cop.cp2_impl     <= impl_field; // RULE_17
      end
      if (take && cop_ok && op_code == DMR_OP_MOVE_TO_CP2) begin
        cop.cp2_wr_data  <= src_b;      // RULE_16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result and exception answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_data  <= '0;
      res_exc   <= DMR_EXC_NONE;
    end else if (cop.cp2_rd_valid && cp2_wait) begin
      res_valid <= 1'b1;
      res_data  <= cop.cp2_rd_data; // RULE_15
      res_exc   <= DMR_EXC_NONE;
    end else if (take && !(op_code == DMR_OP_MOVE_FROM_CP2 && cop_ok) && op_code != DMR_OP_NONE) begin
      res_valid <= 1'b1;
      res_data  <= '0;
      res_exc   <= DMR_EXC_NONE;
      if (is_cop && !cop_ok) begin
        res_exc <= DMR_EXC_UNUSABLE; // RULE_19
      end else begin
        unique case (op_code)
          DMR_OP_ROT_FIXED:   res_data <= rot_right(src_b, {1'b0, shift_amount_field});   // RULE_06
          DMR_OP_ROT_PLUS32:  res_data <= rot_right(src_b, {ROT32_PREFIX, shift_amount_field}); // RULE_07
          DMR_OP_ROT_VAR:     res_data <= rot_right(src_b, src_a[ROT_W-1:0]);              // RULE_08
          DMR_OP_SWAP_BYTES: begin
            if (release_one) begin
              res_exc <= DMR_EXC_RESERVED; // RULE_10
            end else begin
              res_data <= swap_bytes(src_b); // RULE_09
            end
          end
          DMR_OP_READ_BOTTOM: res_data <= bottom_result_reg; // RULE_05
          DMR_OP_READ_UPPER:  res_data <= upper_result_reg;  // RULE_05
          default:            res_data <= '0;
        endcase
      end
    end else begin
      res_valid <= 1'b0;
    end
  end

endmodule

// >>> rtl/dmr_coproc.sv
// coprocessor end: system, float and coprocessor 2 register storage
`timescale 1ns/1ns
module dmr_coproc
  import dmr_pkg::*;
(
  input  wire logic                  ref_clk,     // core clock
  input  wire logic                  rst_n,       // async reset, active low
  input  wire logic [2:0]            usable_in,   // unit enables from status
  output logic [DATA_W-1:0]          sys_value,   // last system register written
  output logic [DATA_W-1:0]          flt_value,   // last float register written
  dmr_cop_if.cop                     cop          // datapath side
);

  localparam int unsigned CP2_DEPTH = 16;

  logic [DATA_W-1:0] cp2_regs [CP2_DEPTH];
  logic [3:0]        cp2_addr;

  assign cop.cop_usable = usable_in;
  // the field is decoded only here; low bits pick a local register
  assign cp2_addr = cop.cp2_impl[3:0]; // RULE_17

  ////////////////////////////////////////////////////////////////////////
  // coprocessor 2 storage and read answer one cycle after request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CP2_DEPTH; i++) begin
        cp2_regs[i] <= '0;
      end
      cop.cp2_rd_valid <= 1'b0;
      cop.cp2_rd_data  <= '0;
    end else begin
      if (cop.cp2_wr_valid) begin
        cp2_regs[cp2_addr] <= cop.cp2_wr_data; // RULE_16
      end
      cop.cp2_rd_valid <= cop.cp2_rd_req;
      if (cop.cp2_rd_req) begin
        cop.cp2_rd_data <= cp2_regs[cp2_addr]; // RULE_15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system and float captures; unused subindex assumed zero by software
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_value <= '0;
      flt_value <= '0;
    end else begin
      if (cop.sys_wr_valid) begin
        sys_value <= cop.sys_wr_data; // RULE_11 RULE_12
      end
      if (cop.flt_wr_valid) begin
        flt_value <= cop.flt_wr_data; // RULE_14
      end
    end
  end

endmodule

// >>> verification/dmr_monitor.sv
// concurrent checks on the coprocessor side of the datapath
`timescale 1ns/1ns
module dmr_monitor
  import dmr_pkg::*;
(
  input wire logic              ref_clk,      // core clock
  input wire logic              rst_n,        // async reset, active low
  input wire logic              sys_wr_valid, // system write strobe
  input wire logic [DATA_W-1:0] sys_wr_data,  // system doubleword
  input wire logic              flt_wr_valid, // float write strobe
  input wire logic [DATA_W-1:0] flt_wr_data,  // float doubleword
  input wire logic              cp2_wr_valid, // cp2 write strobe
  input wire logic              cp2_rd_req,   // cp2 read request
  input wire logic              cp2_rd_valid, // cp2 read answer
  input wire logic [IMPL_W-1:0] cp2_impl,     // cp2 field
  input wire logic [2:0]        cop_usable    // unit enables
);
  ////////////////////////////////////////
  // all checks live in the one clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // a strobe toward a unit needs that unit enabled when the move was taken
  a_sys_needs_usable: assert property (sys_wr_valid |-> $past(cop_usable[0]))
    else $error("system write while unit disabled");
  a_flt_needs_usable: assert property (flt_wr_valid |-> $past(cop_usable[1]))
    else $error("float write while unit disabled");
  a_cp2_needs_usable: assert property ((cp2_wr_valid || cp2_rd_req) |-> $past(cop_usable[2]))
    else $error("cp2 access while unit disabled");
  // cp2 answers a read on the next cycle, and only a read
  a_cp2_read_answer: assert property (cp2_rd_req |=> cp2_rd_valid)
    else $error("cp2 read not answered");
  a_cp2_answer_cause: assert property ($rose(cp2_rd_valid) |-> $past(cp2_rd_req))
    else $error("cp2 answer without request");
  // one instruction moves at most one doubleword
  a_one_move_only: assert property ($onehot0({sys_wr_valid, flt_wr_valid, cp2_wr_valid, cp2_rd_req}))
    else $error("two moves at once");
  // move data stays put between moves
  a_sys_data_hold: assert property (!sys_wr_valid |-> $stable(sys_wr_data))
    else $error("system data moved without strobe");
  a_flt_data_hold: assert property (!flt_wr_valid |-> $stable(flt_wr_data))
    else $error("float data moved without strobe");
  a_cp2_field_hold: assert property (!(cp2_wr_valid || cp2_rd_req) |-> $stable(cp2_impl))
    else $error("cp2 field moved without access");
endmodule

// >>> verification/doubleword_mul_rotate_move_bench.sv
// self-checking bench joining the datapath and the coprocessor end
`timescale 1ns/1ns
module doubleword_mul_rotate_move_bench;
  import dmr_pkg::*;
  logic ref_clk, rst_n, release_one, op_valid, op_ready, res_valid, mul_busy;
  dmr_op_e op_code;
  dmr_exc_e res_exc, exc;
  logic [63:0] src_a, src_b, res_data, got, sys_value, flt_value;
  logic [4:0] shift_amount_field, dest_index;
  logic [2:0] dest_sel, usable;
  logic [15:0] impl_field;
  int failures = 0;
  int cmp_count = 0;

  dmr_cop_if i_dmr_cop_if();
  dmr_core i_dmr_core(.ref_clk(ref_clk), .rst_n(rst_n), .release_one(release_one), .op_valid(op_valid),
    .op_code(op_code), .src_a(src_a), .src_b(src_b), .shift_amount_field(shift_amount_field),
    .dest_index(dest_index), .dest_sel(dest_sel), .impl_field(impl_field), .op_ready(op_ready),
    .res_valid(res_valid), .res_data(res_data), .res_exc(res_exc), .mul_busy(mul_busy), .cop(i_dmr_cop_if));
  dmr_coproc i_dmr_coproc(.ref_clk(ref_clk), .rst_n(rst_n), .usable_in(usable), .sys_value(sys_value),
    .flt_value(flt_value), .cop(i_dmr_cop_if));
  dmr_monitor i_dmr_monitor(.ref_clk(ref_clk), .rst_n(rst_n), .sys_wr_valid(i_dmr_cop_if.sys_wr_valid),
    .sys_wr_data(i_dmr_cop_if.sys_wr_data), .flt_wr_valid(i_dmr_cop_if.flt_wr_valid),
    .flt_wr_data(i_dmr_cop_if.flt_wr_data), .cp2_wr_valid(i_dmr_cop_if.cp2_wr_valid),
    .cp2_rd_req(i_dmr_cop_if.cp2_rd_req), .cp2_rd_valid(i_dmr_cop_if.cp2_rd_valid),
    .cp2_impl(i_dmr_cop_if.cp2_impl), .cop_usable(i_dmr_cop_if.cop_usable));

  ////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [63:0] rotr(input logic [63:0] b, input int s);
    return (b >> s) | (b << (64 - s));
  endfunction

  // hold the request until taken, then wait for the answer pulse
  task automatic run_op(input dmr_op_e op, input logic [63:0] a, input logic [63:0] b, input logic [4:0] sa);
    int n;
    n = 0;
    op_code = op;
    src_a = a;
    src_b = b;
    shift_amount_field = sa;
    op_valid = 1'b1;
    #1;
    while (op_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    op_valid = 1'b0;
    while (res_valid !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 50) failures++;
    got = res_data;
    exc = res_exc;
    // let an edge pass so the next request never re-raises op_valid in this step
    @(negedge ref_clk);
  endtask

  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // scenarios
  task automatic t_rotate();
    logic [63:0] b = 64'h0123_4567_89ab_cdef;
    for (int k = 0; k < 32; k += 31) begin
      run_op(DMR_OP_ROT_FIXED, 64'h0, b, 5'(k));
      check("rotate fixed", got, rotr(b, k));
      run_op(DMR_OP_ROT_PLUS32, 64'h0, b, 5'(k));
      check("rotate plus32", got, rotr(b, k + 32));
      run_op(DMR_OP_ROT_VAR, 64'hffff_ffff_ffff_ffc0 | 64'(2 * k + 1), b, 5'h0);
      check("rotate variable", got, rotr(b, 2 * k + 1));
    end
  endtask

  // read straight after the multiply so the interlock must hold it off
  task automatic t_multiply();
    logic [63:0] a = 64'hffff_ffff_ffff_fffd;
    logic [63:0] b = 64'h0000_0000_0000_0005;
    logic signed [127:0] ps = $signed(a) * $signed(b);
    logic [127:0] pu = {64'h0, a} * {64'h0, b};
    run_op(DMR_OP_SIGNED_MUL, a, b, 5'h0);
    check("mul exc", 64'(exc), 64'(DMR_EXC_NONE));
    check("mul busy", 64'(mul_busy), 64'h1);
    run_op(DMR_OP_READ_BOTTOM, 64'h0, 64'h0, 5'h0);
    check("signed bottom", got, ps[63:0]);
    run_op(DMR_OP_READ_UPPER, 64'h0, 64'h0, 5'h0);
    check("signed upper", got, ps[127:64]);
    run_op(DMR_OP_UNSIGNED_MUL, a, b, 5'h0);
    check("mulu exc", 64'(exc), 64'(DMR_EXC_NONE));
    run_op(DMR_OP_READ_UPPER, 64'h0, 64'h0, 5'h0);
    check("unsigned upper", got, pu[127:64]);
  endtask

  task automatic t_swap();
    run_op(DMR_OP_SWAP_BYTES, 64'h0, 64'h0123_4567_89ab_cdef, 5'h0);
    check("swap", got, 64'h2301_6745_ab89_efcd);
    release_one = 1'b1;
    run_op(DMR_OP_SWAP_BYTES, 64'h0, 64'h0123_4567_89ab_cdef, 5'h0);
    check("swap exc", 64'(exc), 64'(DMR_EXC_RESERVED));
    release_one = 1'b0;
  endtask

  // moves with units enabled, then refused with all units disabled
  task automatic t_moves();
    dest_index = 5'h0c;
    dest_sel = 3'h2;
    impl_field = 16'h00a5;
    run_op(DMR_OP_MOVE_SYS, 64'h0, 64'hdead_beef_0bad_f00d, 5'h0);
    check("sys index", 64'({i_dmr_cop_if.sys_wr_index, i_dmr_cop_if.sys_wr_sel}), 64'h62);
    @(negedge ref_clk);
    check("sys value", sys_value, 64'hdead_beef_0bad_f00d);
    run_op(DMR_OP_MOVE_FLOAT, 64'h0, 64'h7ff8_0000_0000_0001, 5'h0);
    @(negedge ref_clk);
    check("float value", flt_value, 64'h7ff8_0000_0000_0001);
    run_op(DMR_OP_MOVE_TO_CP2, 64'h0, 64'hc0de_0000_1234_5678, 5'h0);
    check("cp2 field", 64'(i_dmr_cop_if.cp2_impl), 64'h00a5);
    run_op(DMR_OP_MOVE_FROM_CP2, 64'h0, 64'h0, 5'h0);
    check("cp2 read", got, 64'hc0de_0000_1234_5678);
    usable = 3'h0;
    run_op(DMR_OP_MOVE_SYS, 64'h0, 64'h1, 5'h0);
    check("sys exc", 64'(exc), 64'(DMR_EXC_UNUSABLE));
    run_op(DMR_OP_MOVE_FLOAT, 64'h0, 64'h1, 5'h0);
    check("float exc", 64'(exc), 64'(DMR_EXC_UNUSABLE));
    run_op(DMR_OP_MOVE_FROM_CP2, 64'h0, 64'h0, 5'h0);
    check("cp2 exc", 64'(exc), 64'(DMR_EXC_UNUSABLE));
    @(negedge ref_clk);
    check("sys kept", sys_value, 64'hdead_beef_0bad_f00d);
    usable = 3'h7;
  endtask

  ////////////////////////////////////////
  // clock generation
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // watchdog at 4000 cycles, well past the hundred or fewer cycles the scenarios need
  initial begin
    #(8 * 4000);
    failures++;
    wrap_up();
  end

  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    {release_one, op_valid, dest_index, dest_sel, impl_field} = '0;
    {src_a, src_b, shift_amount_field} = '0;
    op_code = DMR_OP_NONE;
    usable = 3'h7;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    t_rotate();
    t_multiply();
    t_swap();
    t_moves();
    wrap_up();
  end
endmodule
